// *** common/tap_pkg.sv ***
// package: opcodes, field positions, masks and states of the test access port
package tap_pkg;
    // ******************************************
    // sizes
    // ******************************************
    localparam int IR_W   = 8;
    localparam int DR_W   = 64;
    localparam int NPIN   = 4;
    localparam int BS_W   = 3 * NPIN;
    localparam int BYP_LEN = 1;
    localparam int WORD_LEN = 32;
    localparam int EN_LEN = 8;
    // ******************************************
    // instruction codes
    // ******************************************
    localparam logic [7:0] OP_EXTEST    = 8'h00;
    localparam logic [7:0] OP_INTEST    = 8'h02;
    localparam logic [7:0] OP_CLAMP     = 8'h03;
    localparam logic [7:0] OP_FLOAT     = 8'h04;
    localparam logic [7:0] OP_SAMPLE    = 8'h05;
    localparam logic [7:0] OP_FACTORY   = 8'h0e;
    localparam logic [7:0] OP_SETTINGS  = 8'h0f;
    localparam logic [7:0] OP_ENABLE    = 8'h10;
    localparam logic [7:0] OP_ERASE     = 8'h30;
    localparam logic [7:0] OP_BLANK     = 8'h60;
    localparam logic [7:0] OP_USERCODE  = 8'hfd;
    localparam logic [7:0] OP_IDCODE    = 8'hfe;
    localparam logic [7:0] OP_BYPASS    = 8'hff;
    localparam logic [7:0] IR_RST_VAL   = OP_IDCODE;
    // ******************************************
    // field positions and masks
    // ******************************************
    localparam int OTP_BIT  = 51;
    localparam int UC_BIT   = 50;
    localparam int CFGS_BIT = 49;
    localparam int LOCK_BIT = 63;
    localparam int BWS_BIT  = 51;
    localparam int BRS_BIT  = 50;
    localparam int BTH_BIT  = 49;
    localparam int CSS_BIT  = 48;
    localparam int PROT_HI  = 39;
    localparam logic [63:0] SECTOR_MASK = 64'h000e_00ff_ffff_ffff;
    localparam logic [63:0] ERASE_MASK  = 64'h0006_00ff_ffff_ffff;
    localparam logic [63:0] CFG_MASK    = 64'h800f_00ff_ffff_ffff;
    localparam logic [1:0]  IR_FIXED    = 2'b01;
    localparam logic [1:0]  ERR_FAIL    = 2'b01;
    localparam logic [1:0]  ERR_OK      = 2'b10;
    // ******************************************
    // tap states
    // ******************************************
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;
endpackage

// *** rtl/jtag_isc_config_and_boundary_scan.sv ***
// test access port with sector select, settings readout and boundary scan
`timescale 1ns/1ps
// Behaviour
// - 64-bit sector select register, documented fields
// - blank sector reads zero, else one
// - error status set on non-blank sector
// - one-time area bit ignored during erase
// - no select for protection, identity sectors
// - 64-bit settings readout register, documented fields
// - lock bit readable, never written by shift
// - bypass bit captures zero in capture
// - sample captures pins without disturbing them
// - preload latches shifted values, no drive
// - clamp: bypass selected, pins from latches
// - float: bypass selected, outputs tri-stated
// - extest drives latches, captures pin inputs
// - intest feeds core inputs, captures outputs
// - identity: fixed 32-bit signature out
// - factory info: 32-bit code out
// - user code: 32-bit value out
// - settings readout: 64 bits, loaded power-up
// - configuration mode overrides sector protection
// - enable enters configuration mode when idle
// - mode status: zero functional, one config
// - protection bit blocks processor write, erase
// - chip-select swap reverses flash mapping
module jtag_isc_config_and_boundary_scan
    import tap_pkg::*;
#(
    parameter logic [31:0] ID_SIGNATURE = 32'h1234_5001  // arbitrary value
) (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic              tck_i,
    input  wire logic              tms_i,
    input  wire logic              tdi_i,
    output logic                   tdo_o,
    output logic                   tdo_oe_n_o,
    input  wire logic [63:0]       nv_settings_i,
    input  wire logic [31:0]       user_code_i,
    input  wire logic [31:0]       factory_code_i,
    input  wire logic [63:0]       sector_blank_i,
    input  wire logic              flash_busy_i,
    input  wire logic [NPIN-1:0]   pin_in_i,
    input  wire logic [NPIN-1:0]   core_out_i,
    input  wire logic [NPIN-1:0]   core_oe_n_i,
    output logic      [NPIN-1:0]   pin_out_o,
    output logic      [NPIN-1:0]   pin_oe_n_o,
    output logic      [NPIN-1:0]   core_in_o,
    output logic                   erase_req_o,
    output logic      [63:0]       erase_sel_o,
    output logic                   blank_err_o,
    output logic                   isc_mode_o,
    output logic                   prot_bypass_o,
    output logic      [PROT_HI:0]  sector_lock_o,
    output logic                   cs_swap_o,
    output logic                   brownout_warning_source_o,
    output logic                   brownout_reset_source_o,
    output logic                   brownout_threshold_select_o
);
    // ******************************************
    // decode helpers
    // ******************************************
    function automatic logic bypass_like(input logic [7:0] ir);
        return !(ir inside {OP_EXTEST, OP_INTEST, OP_SAMPLE, OP_FACTORY, OP_SETTINGS,
                            OP_ENABLE, OP_ERASE, OP_BLANK, OP_USERCODE, OP_IDCODE});
    endfunction

    function automatic logic is_boundary(input logic [7:0] ir);
        return ir inside {OP_EXTEST, OP_INTEST, OP_SAMPLE};
    endfunction

    function automatic int dr_len(input logic [7:0] ir);
        if (bypass_like(ir)) begin
            return BYP_LEN;
        end else if (is_boundary(ir)) begin
            return BS_W;
        end else if (ir inside {OP_SETTINGS, OP_ERASE, OP_BLANK}) begin
            return DR_W;
        end else if (ir == OP_ENABLE) begin
            return EN_LEN;
        end
        return WORD_LEN;
    endfunction

    // ******************************************
    // system clock domain
    // ******************************************
    logic              loaded_r;
    logic [63:0]       settings_r;
    logic [31:0]       ucode_r;
    logic [31:0]       fcode_r;
    logic [2:0]        req_sync_r;
    logic [2:0]        enq_sync_r;
    logic [2:0]        upd_sync_r;
    logic [1:0]        drive_sync_r;
    logic [1:0]        float_sync_r;
    logic [1:0]        intest_sync_r;
    logic [NPIN-1:0]   pin_s1_r;
    logic [NPIN-1:0]   pin_s2_r;
    logic [BS_W-1:0]   bs_copy_r;
    logic [63:0]       blank_res_r;
    logic              done_tgl_r;
    logic [1:0]        busy_err_r;

    // tck-domain signals read here only through synchronisers or after a toggle
    logic              req_tgl_r;
    logic              enq_tgl_r;
    logic              req_erase_r;
    logic [63:0]       sec_sel_r;
    logic              upd_tgl_r;
    logic [BS_W-1:0]   bs_latch_r;
    logic [7:0]        ir_r;

    // the strap inputs are caught by a clocked process just after reset release
    // power-up settings load
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            loaded_r   <= 1'b0;
            settings_r <= '0;
            ucode_r    <= '0;
            fcode_r    <= '0;
        end else if (!loaded_r) begin
            loaded_r   <= 1'b1;
            settings_r <= nv_settings_i & CFG_MASK;
            ucode_r    <= user_code_i;
            fcode_r    <= factory_code_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            req_sync_r    <= '0;
            enq_sync_r    <= '0;
            upd_sync_r    <= '0;
            drive_sync_r  <= '0;
            float_sync_r  <= '0;
            intest_sync_r <= '0;
            pin_s1_r      <= '0;
            pin_s2_r      <= '0;
        end else begin
            req_sync_r    <= {req_sync_r[1:0], req_tgl_r};
            enq_sync_r    <= {enq_sync_r[1:0], enq_tgl_r};
            upd_sync_r    <= {upd_sync_r[1:0], upd_tgl_r};
            drive_sync_r  <= {drive_sync_r[0], ir_r inside {OP_EXTEST, OP_CLAMP, OP_INTEST}};
            float_sync_r  <= {float_sync_r[0], ir_r == OP_FLOAT};
            intest_sync_r <= {intest_sync_r[0], ir_r == OP_INTEST};
            pin_s1_r      <= pin_in_i;
            pin_s2_r      <= pin_s1_r;
        end
    end

    // enter configuration mode only while idle
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            isc_mode_o <= 1'b0;
        end else if ((enq_sync_r[2] ^ enq_sync_r[1]) && !flash_busy_i) begin
            isc_mode_o <= 1'b1;
        end
    end

    // sector requests: latched word is stable while the toggle travels
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            erase_req_o <= 1'b0;
            erase_sel_o <= '0;
            blank_res_r <= '1;
            blank_err_o <= 1'b0;
            busy_err_r  <= ERR_OK;
            done_tgl_r  <= 1'b0;
        end else begin
            erase_req_o <= 1'b0;
            if (req_sync_r[2] ^ req_sync_r[1]) begin
                done_tgl_r <= ~done_tgl_r;
                if (req_erase_r) begin
                    erase_req_o <= isc_mode_o;
                    erase_sel_o <= sec_sel_r & ERASE_MASK;
                end else begin
                    blank_res_r <= ~(sec_sel_r & sector_blank_i) & SECTOR_MASK;
                    blank_err_o <= |(sec_sel_r & ~sector_blank_i);
                    busy_err_r  <= |(sec_sel_r & ~sector_blank_i) ? ERR_FAIL : ERR_OK;
                end
            end
        end
    end

    // ******************************************
    // pin and core multiplexing
    // ******************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bs_copy_r <= '0;
        end else if (upd_sync_r[2] ^ upd_sync_r[1]) begin
            bs_copy_r <= bs_latch_r;
        end
    end

    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        always_ff @(posedge clock_i) begin
            if (rst_i) begin
                pin_out_o[i]  <= 1'b0;
                pin_oe_n_o[i] <= 1'b1;
                core_in_o[i]  <= 1'b0;
            end else begin
                if (float_sync_r[1]) begin
                    pin_out_o[i]  <= 1'b0;
                    pin_oe_n_o[i] <= 1'b1;
                end else if (drive_sync_r[1]) begin
                    pin_out_o[i]  <= bs_copy_r[3*i+1];
                    pin_oe_n_o[i] <= bs_copy_r[3*i+2];
                end else begin
                    pin_out_o[i]  <= core_out_i[i];
                    pin_oe_n_o[i] <= core_oe_n_i[i];
                end
                core_in_o[i] <= intest_sync_r[1] ? bs_copy_r[3*i] : pin_s2_r[i];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            prot_bypass_o               <= 1'b0;
            sector_lock_o               <= '0;
            cs_swap_o                   <= 1'b0;
            brownout_warning_source_o   <= 1'b0;
            brownout_reset_source_o     <= 1'b0;
            brownout_threshold_select_o <= 1'b0;
        end else begin
            prot_bypass_o               <= isc_mode_o;
            sector_lock_o               <= settings_r[PROT_HI:0];
            cs_swap_o                   <= settings_r[CSS_BIT];
            brownout_warning_source_o   <= settings_r[BWS_BIT];
            brownout_reset_source_o     <= settings_r[BRS_BIT];
            brownout_threshold_select_o <= settings_r[BTH_BIT];
        end
    end

    // ******************************************
    // link clock domain
    // ******************************************
    tap_state_t        st_r;
    tap_state_t        st_nxt;
    logic [1:0]        trst_r;
    logic [2:0]        done_sync_r;
    logic [1:0]        load_sync_r;
    logic [1:0]        mode_sync_r;
    logic [1:0]        busy_sync_r;
    logic [NPIN-1:0]   tpin_s1_r;
    logic [NPIN-1:0]   tpin_s2_r;
    logic [NPIN-1:0]   tout_s1_r;
    logic [NPIN-1:0]   tout_s2_r;
    logic [NPIN-1:0]   toe_s1_r;
    logic [NPIN-1:0]   toe_s2_r;
    logic [63:0]       blank_seen_r;
    logic [1:0]        err_seen_r;
    logic [63:0]       dr_r;
    logic [7:0]        irsh_r;
    logic [BS_W-1:0]   bs_cap;
    int                len;

    always_ff @(posedge tck_i) begin
        trst_r      <= {trst_r[0], rst_i};
        done_sync_r <= {done_sync_r[1:0], done_tgl_r};
        load_sync_r <= {load_sync_r[0], loaded_r};
        mode_sync_r <= {mode_sync_r[0], isc_mode_o};
        busy_sync_r <= {busy_sync_r[0], flash_busy_i};
        tpin_s1_r   <= pin_in_i;
        tpin_s2_r   <= tpin_s1_r;
        tout_s1_r   <= core_out_i;
        tout_s2_r   <= tout_s1_r;
        toe_s1_r    <= core_oe_n_i;
        toe_s2_r    <= toe_s1_r;
    end

    always_ff @(posedge tck_i) begin
        if (trst_r[1]) begin
            blank_seen_r <= '1;
            err_seen_r   <= ERR_OK;
        end else if (done_sync_r[2] ^ done_sync_r[1]) begin
            blank_seen_r <= blank_res_r;
            err_seen_r   <= busy_err_r;
        end
    end

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            TLR:     st_nxt = tms_i ? TLR : RTI;
            RTI:     st_nxt = tms_i ? SEL_DR : RTI;
            SEL_DR:  st_nxt = tms_i ? SEL_IR : CAP_DR;
            CAP_DR:  st_nxt = tms_i ? EX1_DR : SH_DR;
            SH_DR:   st_nxt = tms_i ? EX1_DR : SH_DR;
            EX1_DR:  st_nxt = tms_i ? UPD_DR : PA_DR;
            PA_DR:   st_nxt = tms_i ? EX2_DR : PA_DR;
            EX2_DR:  st_nxt = tms_i ? UPD_DR : SH_DR;
            UPD_DR:  st_nxt = tms_i ? SEL_DR : RTI;
            SEL_IR:  st_nxt = tms_i ? TLR : CAP_IR;
            CAP_IR:  st_nxt = tms_i ? EX1_IR : SH_IR;
            SH_IR:   st_nxt = tms_i ? EX1_IR : SH_IR;
            EX1_IR:  st_nxt = tms_i ? UPD_IR : PA_IR;
            PA_IR:   st_nxt = tms_i ? EX2_IR : PA_IR;
            EX2_IR:  st_nxt = tms_i ? UPD_IR : SH_IR;
            UPD_IR:  st_nxt = tms_i ? SEL_DR : RTI;
            default: st_nxt = TLR;
        endcase
    end

    always_ff @(posedge tck_i) begin
        if (trst_r[1]) begin
            st_r <= TLR;
        end else begin
            st_r <= st_nxt;
        end
    end

    // boundary cells: [3i] input, [3i+1] output, [3i+2] output enable (low drives)
    for (genvar i = 0; i < NPIN; i++) begin : g_cap
        assign bs_cap[3*i]   = tpin_s2_r[i];
        assign bs_cap[3*i+1] = tout_s2_r[i];
        assign bs_cap[3*i+2] = toe_s2_r[i];
    end

    assign len = dr_len(ir_r);

    // data and instruction shift paths
    always_ff @(posedge tck_i) begin
        if (trst_r[1]) begin
            dr_r   <= '0;
            irsh_r <= '0;
        end else begin
            case (st_r)
                CAP_DR: begin
                    dr_r <= '0;
                    if (bypass_like(ir_r)) begin
                        dr_r <= '0;
                    end else if (is_boundary(ir_r)) begin
                        dr_r[BS_W-1:0] <= bs_cap;
                    end else begin
                        case (ir_r)
                            OP_IDCODE:   dr_r[31:0] <= ID_SIGNATURE;
                            OP_USERCODE: dr_r[31:0] <= load_sync_r[1] ? ucode_r : '0;
                            OP_FACTORY:  dr_r[31:0] <= load_sync_r[1] ? fcode_r : '0;
                            OP_SETTINGS: dr_r <= load_sync_r[1] ? settings_r : '0;
                            OP_BLANK:    dr_r <= blank_seen_r & SECTOR_MASK;
                            default:     dr_r <= '0;
                        endcase
                    end
                end
                SH_DR: begin
                    dr_r <= dr_r >> 1;
                    dr_r[len-1] <= tdi_i;
                end
                CAP_IR: begin
                    // mode status bit
                    // status byte: error, ready, mode, fixed 01
                    irsh_r <= {2'b00, err_seen_r, ~busy_sync_r[1], mode_sync_r[1], IR_FIXED};
                end
                SH_IR: begin
                    irsh_r <= {tdi_i, irsh_r[7:1]};
                end
                default: begin
                    dr_r <= dr_r;
                end
            endcase
        end
    end

    // updates on the falling edge
    always_ff @(negedge tck_i) begin
        if (trst_r[1] || st_r == TLR) begin
            ir_r <= IR_RST_VAL;
        end else if (st_r == UPD_IR) begin
            ir_r <= irsh_r;
        end
    end

    always_ff @(negedge tck_i) begin
        if (trst_r[1]) begin
            bs_latch_r <= '0;
            upd_tgl_r  <= 1'b0;
        end else if (st_r == UPD_DR && is_boundary(ir_r)) begin
            bs_latch_r <= dr_r[BS_W-1:0];
            upd_tgl_r  <= ~upd_tgl_r;
        end
    end

    always_ff @(negedge tck_i) begin
        if (trst_r[1]) begin
            sec_sel_r   <= '0;
            req_erase_r <= 1'b0;
            req_tgl_r   <= 1'b0;
            enq_tgl_r   <= 1'b0;
        end else if (st_r == UPD_DR && (ir_r == OP_ERASE || ir_r == OP_BLANK)) begin
            sec_sel_r   <= dr_r & SECTOR_MASK;
            req_erase_r <= ir_r == OP_ERASE;
            req_tgl_r   <= ~req_tgl_r;
        end else if (st_r == UPD_IR && irsh_r == OP_ENABLE && !mode_sync_r[1]) begin
            // enable takes effect at instruction update
            enq_tgl_r <= ~enq_tgl_r;
        end
    end

    always_ff @(negedge tck_i) begin
        if (trst_r[1]) begin
            tdo_o      <= 1'b0;
            tdo_oe_n_o <= 1'b1;
        end else begin
            tdo_o      <= (st_r == SH_IR) ? irsh_r[0] : dr_r[0];
            tdo_oe_n_o <= !(st_r == SH_IR || st_r == SH_DR);
        end
    end

endmodule // jtag_isc_config_and_boundary_scan

// *** testbench/jtag_host.sv ***
// partner model: external test controller driving the link
`timescale 1ns/1ps
module jtag_host (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    // ******************************************
    // link cycles, tck stands low between frames
    // ******************************************
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // tdo sampled just before the rising edge that shifts it
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #3;
        tdo = tdo_i;
        tck_o = 1'b1;
        #3;
        tck_o = 1'b0;
    endtask
    // outside a shift tdi carries no data, so it toggles
    task automatic step(input logic tms);
        logic d;
        tick(tms, ~tdi_o, d);
    endtask
    task automatic idle(input int n);
        repeat (n) step(1'b0);
    endtask
    // from idle, one scan, back to idle
    // caller's mask shifted in lsb first
    task automatic scan(input logic ir, input int len, input logic [63:0] din,
                        output logic [63:0] dout);
        logic d;
        dout = 64'h0;
        step(1'b1);
        if (ir) step(1'b1);
        step(1'b0);
        step(1'b0);
        for (int i = 0; i < len; i++) begin
            tick(i == len - 1, din[i], d);
            dout[i] = d;
        end
        step(1'b1);
        step(1'b0);
    endtask
endmodule // jtag_host

// *** testbench/tap_sva.sv ***
// checker: port-level properties of the test access port
`timescale 1ns/1ps
module tap_sva
    import tap_pkg::*;
(
    input wire logic              clock_i,
    input wire logic              rst_i,
    input wire logic [63:0]       nv_settings_i,
    input wire logic              erase_req_o,
    input wire logic [63:0]       erase_sel_o,
    input wire logic              isc_mode_o,
    input wire logic              prot_bypass_o,
    input wire logic [PROT_HI:0]  sector_lock_o,
    input wire logic              cs_swap_o,
    input wire logic              brownout_warning_source_o,
    input wire logic              brownout_reset_source_o,
    input wire logic              brownout_threshold_select_o
);
    // ******************************************
    // settle counter, settings valid from 3 clocks
    // ******************************************
    logic [1:0] settle_r;
    always_ff @(posedge clock_i) begin
        if (rst_i) settle_r <= 2'h0;
        else if (settle_r != 2'h3) settle_r <= settle_r + 2'h1;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    reset_quiet_a: assert property ($fell(rst_i) |-> !isc_mode_o && !erase_req_o)
        else $error("outputs not cleared by reset");
    erase_pulse_a: assert property (erase_req_o |=> !erase_req_o)
        else $error("erase request longer than one clock");
    erase_mode_a: assert property (erase_req_o |-> isc_mode_o)
        else $error("erase outside configuration mode");
    erase_otp_a: assert property (erase_req_o |-> !erase_sel_o[OTP_BIT])
        else $error("one-time area selected for erase");
    erase_reserved_a: assert property (erase_req_o |-> (erase_sel_o & ~ERASE_MASK) == 64'h0)
        else $error("unaddressable sector selected for erase");
    mode_sticky_a: assert property (isc_mode_o |=> isc_mode_o)
        else $error("configuration mode left without reset");
    protect_follow_a: assert property ($rose(isc_mode_o) |-> !prot_bypass_o ##1 prot_bypass_o)
        else $error("protection bypass not following mode");
    settings_hold_a: assert property (settle_r == 2'h3 |->
        sector_lock_o == nv_settings_i[PROT_HI:0] && cs_swap_o == nv_settings_i[CSS_BIT])
        else $error("protection or swap differs from settings image");
    brownout_map_a: assert property (settle_r == 2'h3 |-> {brownout_warning_source_o,
        brownout_reset_source_o, brownout_threshold_select_o} == nv_settings_i[BWS_BIT:BTH_BIT])
        else $error("brownout fields differ from settings image");
endmodule // tap_sva
bind jtag_isc_config_and_boundary_scan tap_sva chk_u (
    .clock_i(clock_i), .rst_i(rst_i), .nv_settings_i(nv_settings_i),
    .erase_req_o(erase_req_o), .erase_sel_o(erase_sel_o), .isc_mode_o(isc_mode_o),
    .prot_bypass_o(prot_bypass_o), .sector_lock_o(sector_lock_o), .cs_swap_o(cs_swap_o),
    .brownout_warning_source_o(brownout_warning_source_o),
    .brownout_reset_source_o(brownout_reset_source_o),
    .brownout_threshold_select_o(brownout_threshold_select_o)
);

// *** testbench/tb.sv ***
// testbench: scenarios for the test access port
`timescale 1ns/1ps
module tb
    import tap_pkg::*;
;
    localparam logic [31:0] SIG = 32'h0bad_5eed;  // arbitrary value
    localparam logic [63:0] NV  = 64'h9abc_def0_1357_9bdf;
    logic clock_i = 1'b0, rst_i = 1'b1, flash_busy_i = 1'b0;
    logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_n_o, erase_req_o, blank_err_o, isc_mode_o;
    logic prot_bypass_o, cs_swap_o, bw_o, br_o, bt_o;
    logic [63:0] nv_settings_i = NV, sector_blank_i = 64'h0, erase_sel_o;
    logic [31:0] user_code_i = 32'h5a5a_0f0f, factory_code_i = 32'hc3c3_1e1e;
    logic [3:0]  pin_in_i = 4'h0, core_out_i = 4'h0, core_oe_n_i = 4'hf;
    logic [3:0]  pin_out_o, pin_oe_n_o, core_in_o;
    logic [39:0] sector_lock_o;
    int n_errors = 0, total_checks = 0, cycles = 0;
    always #2.5 clock_i = ~clock_i;
    jtag_isc_config_and_boundary_scan #(.ID_SIGNATURE(SIG)) dut_u (
        .clock_i(clock_i), .rst_i(rst_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
        .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .nv_settings_i(nv_settings_i),
        .user_code_i(user_code_i), .factory_code_i(factory_code_i),
        .sector_blank_i(sector_blank_i), .flash_busy_i(flash_busy_i), .pin_in_i(pin_in_i),
        .core_out_i(core_out_i), .core_oe_n_i(core_oe_n_i), .pin_out_o(pin_out_o),
        .pin_oe_n_o(pin_oe_n_o), .core_in_o(core_in_o), .erase_req_o(erase_req_o),
        .erase_sel_o(erase_sel_o), .blank_err_o(blank_err_o), .isc_mode_o(isc_mode_o),
        .prot_bypass_o(prot_bypass_o), .sector_lock_o(sector_lock_o), .cs_swap_o(cs_swap_o),
        .brownout_warning_source_o(bw_o), .brownout_reset_source_o(br_o),
        .brownout_threshold_select_o(bt_o));
    jtag_host host_u (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o));
    // ******************************************
    // shared tasks
    // ******************************************
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ir(input logic [7:0] op, output logic [63:0] st);
        host_u.scan(1'b1, 8, {56'h0, op}, st);
    endtask
    // data shifted in is all ones, which a readout must ignore
    task automatic rd(input logic [7:0] op, input int len, input logic [63:0] exp,
                      input string what);
        logic [63:0] q;
        ir(op, q);
        host_u.scan(1'b0, len, {64{1'b1}}, q);
        chk(what, exp, q);
    endtask
    // pin paths cross through two flops, so allow ten clocks
    task automatic settle;
        repeat (10) @(posedge clock_i);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ******************************************
    // scenarios
    // ******************************************
    task automatic readouts;
        logic [63:0] st;
        ir(OP_IDCODE, st);
        chk("ir capture", 64'h29, st);
        rd(OP_IDCODE, 32, {32'h0, SIG}, "idcode");
        rd(OP_USERCODE, 32, {32'h0, user_code_i}, "usercode");
        rd(OP_FACTORY, 32, {32'h0, factory_code_i}, "factory");
        rd(OP_SETTINGS, 64, NV & CFG_MASK, "settings");
        rd(OP_SETTINGS, 64, NV & CFG_MASK, "settings reread");
        rd(OP_BYPASS, 2, 64'h2, "bypass");
        rd(8'h77, 2, 64'h2, "unknown opcode");
        chk("tdo released", 64'h1, {63'h0, tdo_oe_n_o});
    endtask
    task automatic boundary;
        logic [63:0] q;
        @(posedge clock_i);
        pin_in_i <= 4'hf;
        core_out_i <= 4'hf;
        settle;
        ir(OP_SAMPLE, q);
        host_u.scan(1'b0, 12, 64'h0, q);
        chk("sample capture", 64'hfff, q);
        settle;
        chk("preload oe", 64'hf, {60'h0, pin_oe_n_o});
        rd(OP_CLAMP, 2, 64'h2, "clamp bypass");
        settle;
        chk("clamp oe", 64'h0, {60'h0, pin_oe_n_o});
        ir(OP_FLOAT, q);
        settle;
        chk("float oe", 64'hf, {60'h0, pin_oe_n_o});
        ir(OP_EXTEST, q);
        settle;
        chk("extest drive", 64'h0, {56'h0, pin_oe_n_o, pin_out_o});
        ir(OP_INTEST, q);
        settle;
        chk("intest core in", 64'h0, {60'h0, core_in_o});
    endtask
    task automatic config_flow;
        logic [63:0] q, sel;
        logic hit;
        hit = 1'b0;
        ir(OP_ENABLE, q);
        host_u.scan(1'b0, 8, 64'h0, q);
        settle;
        chk("mode", 64'h1, {63'h0, isc_mode_o});
        chk("protect bypass", 64'h1, {63'h0, prot_bypass_o});
        ir(OP_ERASE, q);
        fork
            host_u.scan(1'b0, 64, {64{1'b1}}, q);
            repeat (100) begin
                @(negedge clock_i);
                if (erase_req_o === 1'b1) begin
                    hit = 1'b1;
                    sel = erase_sel_o;
                end
            end
        join
        chk("erase request", 64'h1, {63'h0, hit});
        chk("erase mask", ERASE_MASK, sel);
        @(posedge clock_i);
        sector_blank_i <= 64'h7;
        ir(OP_BLANK, q);
        host_u.scan(1'b0, 64, 64'hf, q);
        settle;
        host_u.idle(8);
        host_u.scan(1'b0, 64, 64'hf, q);
        chk("blank result", 64'h8, q & 64'hf);
        chk("blank reserved", 64'h0, q & ~SECTOR_MASK);
        chk("blank error", 64'h1, {63'h0, blank_err_o});
        ir(OP_BYPASS, q);
        chk("ir status", 64'h1d, q);
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop;
        end
    end
    initial begin
        fork
            repeat (6) @(posedge clock_i);
            repeat (5) host_u.step(1'b1);
        join
        @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (5) host_u.step(1'b1);
        host_u.step(1'b0);
        readouts;
        boundary;
        config_flow;
        report_and_stop;
    end
endmodule // tb
